//--- core/phy_regs_pkg.sv
// Constants and types for the PHY status and power control registers
package phy_regs_pkg;
  localparam int          ADDR_W            = 5;
  localparam logic [4:0]  STATUS_OFFSET     = 5'h10;
  localparam logic [4:0]  CONTROL_OFFSET    = 5'h11;
  localparam logic [15:0] STATUS_RESET      = 16'h0000;
  localparam logic [15:0] CONTROL_RESET     = 16'h0108;
  // Write mask clears reserved bit 10; low mask marks plain storage bits below the power fields
  localparam logic [15:0] CONTROL_WR_MASK   = 16'hfbff;
  localparam logic [15:0] CONTROL_LOW_MASK  = 16'h030f;
  localparam int          ST_LINK_BIT       = 0;
  localparam int          ST_SPEED_BIT      = 1;
  localparam int          ST_DUPLEX_BIT     = 2;
  localparam int          ST_LOOPBACK_BIT   = 3;
  localparam int          CT_CLKDIS_BIT     = 15;
  localparam int          CT_PSAVE_EN_BIT   = 14;
  localparam int          CT_MODE_HI        = 13;
  localparam int          CT_MODE_LO        = 12;
  localparam int          CT_SCR_BYPASS_BIT = 11;
  localparam int          CT_RSVD_BIT       = 10;
  localparam logic [1:0]  MODE_NORMAL       = 2'h0;
  localparam logic [1:0]  MODE_RESERVED     = 2'h1;
  localparam logic [1:0]  MODE_ACTIVE_SLEEP = 2'h2;
  localparam int          NLP_PERIOD_MS     = 1400;
  localparam int          CLK_MHZ           = 200;
  localparam int          NLP_PERIOD_CYCLES = NLP_PERIOD_MS * CLK_MHZ * 1000;

  typedef struct packed {
    logic loopback;
    logic fullDuplex;
    logic speed10;
    logic linkUp;
  } phy_status_in_t;

  typedef struct packed {
    logic              wrEn;
    logic              rdEn;
    logic [ADDR_W-1:0] addr;
    logic [15:0]       wrData;
  } mgmt_req_t;

  typedef enum logic [2:0] {
    PWR_ON     = 3'b001,
    PWR_SLEEP  = 3'b010,
    PWR_CLKOFF = 3'b100
  } pwr_state_t;
endpackage

//--- core/phy_status_and_power_control_regs.sv
// Status and power control registers of the PHY management space
// Behaviour
// - Loopback status bit reads 1 during internal loopback, else 0.
// - Duplex status bit reads 1 for full duplex, 0 for half.
// - Speed status bit reads 0 at 100 Mbps, 1 at 10 Mbps.
// - Link status mirrors basic status link bit; reading never clears it.
// - Clock disable stops clocks only while in IEEE power-down.
// - Power-save enable lets selected mode act; cleared keeps normal.
// - Mode 0 is normal operation; mode 1 reserved, host avoids it.
// - Active sleep powers down all but management and energy detect, pulses.
// - Active sleep wakes automatically on detected energy, no write needed.
// - Scrambler bypass bit routes data around scrambler; resets to 0.
// - Status register resets to zero and sits at offset 0x10.
`timescale 1ns/10ps
`default_nettype none
module phy_status_and_power_control_regs
  import phy_regs_pkg::*;
#(
  parameter int NLP_CYCLES = NLP_PERIOD_CYCLES,
  parameter int CNT_W      = 32
) (
  input  wire logic           ref_clk,
  input  wire logic           resetn,
  input  wire mgmt_req_t      mgmtReq,
  output logic [15:0]         regRdData,
  input  wire phy_status_in_t statusIn,
  input  wire logic           ieeePowerDown,
  input  wire logic           energyPin,
  output logic                clocksOff,
  output logic                circuitsDown,
  output logic                nlpPulse,
  output logic                scramblerBypass
);
  // Pulse counter must hold the whole period and still pulse once a period
  if (NLP_CYCLES < 2 || CNT_W > 32 ||
      NLP_CYCLES >= (64'd1 << CNT_W)) begin : g_bad_nlp
    $error("NLP_CYCLES does not fit the pulse counter");
  end

  localparam logic [CNT_W-1:0] NLP_LAST = CNT_W'(NLP_CYCLES - 1);

  logic [15:0]      statusReg;
  logic [15:0]      next_statusReg;
  logic [15:0]      ctrl;
  logic [15:0]      next_ctrl;
  logic [15:0]      next_regRdData;
  logic [2:0]       energySync;
  logic             energyDet;
  logic             next_energyDet;
  logic             armed;
  logic             next_armed;
  pwr_state_t       state;
  pwr_state_t       next_state;
  logic [CNT_W-1:0] nlpCnt;
  logic [CNT_W-1:0] next_nlpCnt;
  logic             next_nlpPulse;
  logic             next_clocksOff;
  logic             next_circuitsDown;
  logic             next_scramblerBypass;
  logic [1:0]       mode;
  logic             ctrlWrite;
  logic             sleepReq;

  assign mode      = ctrl[CT_MODE_HI:CT_MODE_LO];
  assign ctrlWrite = mgmtReq.wrEn && mgmtReq.addr == CONTROL_OFFSET;
  // Mode 0 and reserved mode 1 both keep the device fully functional
  assign sleepReq  = ctrl[CT_PSAVE_EN_BIT]
                  && mode == MODE_ACTIVE_SLEEP;

  // Register file
  always_comb begin
    next_statusReg = STATUS_RESET;
    next_statusReg[ST_LOOPBACK_BIT] = statusIn.loopback;
    next_statusReg[ST_DUPLEX_BIT]   = statusIn.fullDuplex;
    next_statusReg[ST_SPEED_BIT]    = statusIn.speed10;
    // Plain mirror, so a read has no side effect on it
    next_statusReg[ST_LINK_BIT]     = statusIn.linkUp;
    next_ctrl = ctrl;
    if (ctrlWrite) begin
      next_ctrl = mgmtReq.wrData & CONTROL_WR_MASK;
    end
    next_regRdData = regRdData;
    if (mgmtReq.rdEn) begin
      case (mgmtReq.addr)
        STATUS_OFFSET:  next_regRdData = statusReg;
        CONTROL_OFFSET: next_regRdData = ctrl;
        default:        next_regRdData = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      statusReg <= STATUS_RESET;
      ctrl      <= CONTROL_RESET;
      regRdData <= 16'h0000;
    end else begin
      statusReg <= next_statusReg;
      ctrl      <= next_ctrl;
      regRdData <= next_regRdData;
    end
  end

  // Energy detect comes from the analog front end, so it is synchronised
  always_comb begin
    next_energyDet = energyDet;
    if (energySync[1] == energySync[2]) begin
      next_energyDet = energySync[2];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      energySync <= 3'h0;
      energyDet  <= 1'b0;
    end else begin
      energySync <= {energySync[1:0], energyPin};
      energyDet  <= next_energyDet;
    end
  end

  // Power state machine
  always_comb begin
    next_state           = state;
    next_armed           = armed;
    next_nlpCnt          = nlpCnt;
    next_nlpPulse        = 1'b0;
    // Any control write re-arms sleep after an automatic wake
    if (ctrlWrite) begin
      next_armed = 1'b1;
    end
    case (state)
      PWR_ON: begin
        next_nlpCnt = '0;
        if (ctrl[CT_CLKDIS_BIT] && ieeePowerDown) begin
          next_state = PWR_CLKOFF;
        end else if (sleepReq && armed && !energyDet) begin
          next_state = PWR_SLEEP;
        end
      end
      PWR_SLEEP: begin
        if (energyDet || !sleepReq) begin
          next_state = PWR_ON;
          next_armed = ctrlWrite;
          next_nlpCnt = '0;
        end else if (nlpCnt == NLP_LAST) begin
          next_nlpCnt   = '0;
          next_nlpPulse = 1'b1;
        end else begin
          next_nlpCnt = nlpCnt + 1'b1;
        end
      end
      PWR_CLKOFF: begin
        if (!(ctrl[CT_CLKDIS_BIT] && ieeePowerDown)) begin
          next_state = PWR_ON;
        end
      end
      default: next_state = PWR_ON;
    endcase
    next_clocksOff       = next_state == PWR_CLKOFF;
    next_circuitsDown    = next_state == PWR_SLEEP;
    next_scramblerBypass = ctrl[CT_SCR_BYPASS_BIT];
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state           <= PWR_ON;
      armed           <= 1'b1;
      nlpCnt          <= '0;
      nlpPulse        <= 1'b0;
      clocksOff       <= 1'b0;
      circuitsDown    <= 1'b0;
      scramblerBypass <= 1'b0;
    end else begin
      state           <= next_state;
      armed           <= next_armed;
      nlpCnt          <= next_nlpCnt;
      nlpPulse        <= next_nlpPulse;
      clocksOff       <= next_clocksOff;
      circuitsDown    <= next_circuitsDown;
      scramblerBypass <= next_scramblerBypass;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  AST_LOOPBACK: assert property (
    mgmtReq.rdEn && mgmtReq.addr == STATUS_OFFSET ##1 $past(resetn, 2)
    |-> regRdData[ST_LOOPBACK_BIT] == $past(statusIn.loopback, 2))
    else $error("loopback status wrong");
  AST_DUPLEX: assert property (
    $past(resetn) |-> statusReg[ST_DUPLEX_BIT] == $past(statusIn.fullDuplex))
    else $error("duplex status wrong");
  AST_SPEED: assert property (
    $past(resetn) |-> statusReg[ST_SPEED_BIT] == $past(statusIn.speed10))
    else $error("speed status wrong");
  AST_LINK_KEPT: assert property (
    mgmtReq.rdEn && mgmtReq.addr == STATUS_OFFSET && statusReg[ST_LINK_BIT]
    ##1 statusIn.linkUp |-> regRdData[ST_LINK_BIT] ##1 statusReg[ST_LINK_BIT])
    else $error("link status lost on read");
  AST_CLKOFF: assert property (
    clocksOff |-> $past(ctrl[CT_CLKDIS_BIT] && ieeePowerDown))
    else $error("clocks stopped outside power-down");
  AST_SLEEP_CAUSE: assert property (
    $rose(circuitsDown) |-> $past(ctrl[CT_PSAVE_EN_BIT])
    && $past(mode) == MODE_ACTIVE_SLEEP)
    else $error("sleep without enable and mode 2");
  AST_NLP_IN_SLEEP: assert property (
    nlpPulse |-> circuitsDown ##1 !nlpPulse)
    else $error("link pulse outside sleep");
  AST_WAKE: assert property (
    state == PWR_SLEEP && energyDet |=> state == PWR_ON && !circuitsDown)
    else $error("no automatic wake");
  AST_SCR: assert property (
    ##1 scramblerBypass == $past(ctrl[CT_SCR_BYPASS_BIT]))
    else $error("scrambler bypass mismatch");
  AST_STATUS_RESET: assert property (
    disable iff (1'b0) !resetn |=> statusReg == STATUS_RESET)
    else $error("status not zero after reset");
  AST_RSVD: assert property (
    mgmtReq.rdEn && mgmtReq.addr == CONTROL_OFFSET |=> !regRdData[CT_RSVD_BIT])
    else $error("reserved control bit reads 1");

  COV_SLEEP: cover property ($rose(circuitsDown));
  COV_NLP: cover property (nlpPulse);
  COV_WAKE: cover property (state == PWR_SLEEP ##1 state == PWR_ON);
  COV_CLKOFF: cover property ($rose(clocksOff));
endmodule
`default_nettype wire

//--- verification/mgmt_host_model.sv
// Management host model issuing register requests
`timescale 1ns/10ps
`default_nettype none
module mgmt_host_model
  import phy_regs_pkg::*;
(
  input  wire logic ref_clk,
  output mgmt_req_t mgmtReq
);
  initial mgmtReq = '0;
  // Idle bus shows inverted fields so stale values never look valid
  task automatic xfer(input logic w, input logic [4:0] a,
                      input logic [15:0] d);
    @(posedge ref_clk);
    #1 mgmtReq = '{w, !w, a, d};
    @(posedge ref_clk);
    #1 mgmtReq = '{1'b0, 1'b0, ~a, ~d};
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    if (d[13:12] == MODE_RESERVED)
      d[13:12] = MODE_NORMAL;
    xfer(1'b1, a, d);
  endtask
endmodule
`default_nettype wire

//--- verification/phy_status_and_power_control_regs_tb.sv
// Self-checking bench for the PHY status and power control registers
`timescale 1ns/10ps
`default_nettype none
module phy_status_and_power_control_regs_tb
  import phy_regs_pkg::*;
;
  localparam int  NORMAL_LINK_PULSE           = 20;
  logic           ref_clk       = 1'b0;
  logic           resetn        = 1'b0;
  logic           ieeePowerDown = 1'b0;
  logic           energyPin     = 1'b0;
  phy_status_in_t statusIn      = '0;
  mgmt_req_t      mgmtReq;
  logic [15:0]    regRdData;
  logic           clocksOff;
  logic           circuitsDown;
  logic           nlpPulse;
  logic           scramblerBypass;
  logic [15:0]    expQ[$];
  logic           rdPrev        = 1'b0;
  int             error_cnt     = 0;
  int             n_compared    = 0;
  logic [31:0]    seed          = 32'h7be5d188;
  logic [15:0]    v;
  int             n;
  always #2.5 ref_clk = ~ref_clk;
  mgmt_host_model i_host (.ref_clk(ref_clk), .mgmtReq(mgmtReq));
  phy_status_and_power_control_regs #(.NLP_CYCLES(NORMAL_LINK_PULSE)) i_dut (
    .ref_clk(ref_clk), .resetn(resetn), .mgmtReq(mgmtReq),
    .regRdData(regRdData), .statusIn(statusIn),
    .ieeePowerDown(ieeePowerDown), .energyPin(energyPin),
    .clocksOff(clocksOff), .circuitsDown(circuitsDown),
    .nlpPulse(nlpPulse), .scramblerBypass(scramblerBypass));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk1(input string nm, input logic e, g);
    chk(nm, {15'h0000, e}, {15'h0000, g});
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge ref_clk);
    #1;
  endtask
  task automatic waitPulse(output int c);
    c = 0;
    while (nlpPulse !== 1'b1 && c < 50) begin
      cyc(1);
      c++;
    end
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    expQ.push_back(e);
    i_host.xfer(1'b0, a, 16'(rnd()));
  endtask
  task automatic final_report();
    if (error_cnt == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Read data lands one edge after the request edge
  always @(posedge ref_clk) begin
    if (rdPrev === 1'b1)
      chk("regRdData", expQ.pop_front(), regRdData);
    rdPrev <= mgmtReq.rdEn;
  end
  // About two hundred cycles expected; generous margin
  initial begin
    #100000;
    error_cnt++;
    final_report();
  end
  initial begin
    cyc(8);
    resetn = 1'b1;
    rd(STATUS_OFFSET, STATUS_RESET);
    rd(CONTROL_OFFSET, CONTROL_RESET);
    rd(5'h1f, 16'h0000);
    chk1("scramblerBypass", 1'b0, scramblerBypass);
    for (int i = 0; i < 8; i++) begin
      v = 16'(rnd());
      statusIn = v[3:0];
      i_host.wr(STATUS_OFFSET, ~v);
      rd(STATUS_OFFSET, {12'h000, v[3:0]});
      rd(STATUS_OFFSET, {12'h000, v[3:0]});
      v = (16'(rnd()) & 16'h0fff) | 16'h0400;
      i_host.wr(CONTROL_OFFSET, v);
      rd(CONTROL_OFFSET, v & 16'hfbff);
      chk1("scramblerBypass", v[11], scramblerBypass);
    end
    i_host.wr(CONTROL_OFFSET, 16'h8000);
    cyc(4);
    chk1("clocksOff", 1'b0, clocksOff);
    ieeePowerDown = 1'b1;
    cyc(3);
    chk1("clocksOff", 1'b1, clocksOff);
    ieeePowerDown = 1'b0;
    i_host.wr(CONTROL_OFFSET, 16'h4000);
    cyc(4);
    chk1("circuitsDown", 1'b0, circuitsDown);
    i_host.wr(CONTROL_OFFSET, 16'h2000);
    cyc(4);
    chk1("circuitsDown", 1'b0, circuitsDown);
    i_host.wr(CONTROL_OFFSET, 16'h6000);
    cyc(3);
    chk1("circuitsDown", 1'b1, circuitsDown);
    waitPulse(n);
    cyc(1);
    waitPulse(n);
    chk("nlpSpacing", 16'(NORMAL_LINK_PULSE - 1), 16'(n));
    energyPin = 1'b1;
    cyc(8);
    chk1("circuitsDown", 1'b0, circuitsDown);
    energyPin = 1'b0;
    cyc(8);
    chk1("circuitsDown", 1'b0, circuitsDown);
    rd(CONTROL_OFFSET, 16'h6000);
    // Control write re-arms sleep; a mid-run reset must drop it again
    i_host.wr(CONTROL_OFFSET, 16'h6800);
    cyc(3);
    chk1("circuitsDown", 1'b1, circuitsDown);
    chk1("scramblerBypass", 1'b1, scramblerBypass);
    resetn = 1'b0;
    cyc(2);
    chk1("circuitsDown", 1'b0, circuitsDown);
    chk1("scramblerBypass", 1'b0, scramblerBypass);
    resetn = 1'b1;
    rd(CONTROL_OFFSET, CONTROL_RESET);
    cyc(3);
    final_report();
  end
endmodule
`default_nettype wire
